// [rtl/aux_cmd_defs.svh]
// constants for the auxiliary command decoder
`ifndef AUX_CMD_DEFS_SVH
`define AUX_CMD_DEFS_SVH

`define AUX_CS_BIT         0
`define AUX_CODE_LSB       3
`define AUX_CODE_MSB       7
`define AUX_C_SWRST        5'h00
`define AUX_C_DAC_REL      5'h01
`define AUX_C_RFD_REL      5'h02
`define AUX_C_HOLD_ALL     5'h03
`define AUX_C_HOLD_END     5'h04
`define AUX_C_NBA_FALSE    5'h05
`define AUX_C_TRIGGER      5'h06
`define AUX_C_TO_LOCAL     5'h07
`define AUX_C_FORCE_EOI    5'h08
`define AUX_C_LISTEN_ONLY  5'h09
`define AUX_C_TALK_ONLY    5'h0A
`define AUX_C_STANDBY      5'h0B
`define AUX_C_TAKE_ASYNC   5'h0C
`define AUX_C_TAKE_SYNC    5'h0D
`define AUX_C_PAR_POLL     5'h0E
`define AUX_C_IFC          5'h0F
`define AUX_C_REN          5'h10
`define AUX_C_LAST_DEF     5'h18
`define AUX_TRIG_CYCLES    3'h5
`define AUX_IFC_MIN_NS     100000
`define AUX_CLK_NS         40
`define AUX_IFC_CYCLES     12'((`AUX_IFC_MIN_NS + `AUX_CLK_NS - 1) / `AUX_CLK_NS)
`define AUX_REG_CMD        2'h0
`define AUX_REG_STATUS     2'h1
`define AUX_REG_BUS        2'h2

`endif

// [rtl/aux_cmd_pkg.sv]
// types shared by both ends of the auxiliary command link
package aux_cmd_pkg;
  typedef logic [7:0] aux_byte_t;
  typedef logic [4:0] aux_code_t;
endpackage

// [rtl/aux_cmd_if.sv]
// link between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface aux_cmd_if;
  logic [7:0] cmd_byte;
  logic       cmd_we;
  modport host (output cmd_byte, output cmd_we);
  modport dev  (input cmd_byte, input cmd_we);
endinterface
`default_nettype wire

// [rtl/aux_trig_pulse.sv]
// stretches a one-cycle start into a fixed-length trigger pulse
`timescale 1ns/1ps
`default_nettype none
`include "aux_cmd_defs.svh"
module aux_trig_pulse (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      busy_o
);
  typedef struct packed { logic [2:0] cnt; } st_t;
  st_t st_r;
  st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (start_i) begin
      st_nxt.cnt = `AUX_TRIG_CYCLES;
    end else if (st_r.cnt != 3'h0) begin
      st_nxt.cnt = st_r.cnt - 3'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign busy_o = (st_r.cnt != 3'h0);
endmodule
`default_nettype wire

// [rtl/aux_cmd_host.sv]
// host end: register port for software, forwards command bytes
`timescale 1ns/1ps
`default_nettype none
`include "aux_cmd_defs.svh"
module aux_cmd_host
  import aux_cmd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  aux_cmd_if.host          link
);
  import aux_cmd_pkg::*;
  typedef struct packed {
    aux_byte_t  cmd;
    logic       we;
    aux_byte_t  rdata;
    logic [11:0] ifc_cnt;
    logic        ifc_on;
  } st_t;
  st_t st_r;
  st_t st_nxt;
  // --------------------------------------------------------------------------
  // command forwarding
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.we = 1'b0;
    st_nxt.rdata = 8'h00;
    if (st_r.ifc_on && st_r.ifc_cnt != 12'h000) begin
      st_nxt.ifc_cnt = st_r.ifc_cnt - 12'h001;
    end
    if (wr_i && addr_i == `AUX_REG_CMD) begin
      st_nxt.cmd = wdata_i;
      st_nxt.we  = 1'b1;
      if (wdata_i[`AUX_CODE_MSB:`AUX_CODE_LSB] == `AUX_C_IFC) begin
        st_nxt.ifc_on  = wdata_i[`AUX_CS_BIT];
        st_nxt.ifc_cnt = `AUX_IFC_CYCLES;
      end
    end
    if (rd_i && addr_i == `AUX_REG_STATUS) begin
      // bit0: interface clear held long enough to drop
      st_nxt.rdata = {6'h00, st_r.ifc_on, st_r.ifc_on && st_r.ifc_cnt == 12'h000};
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign link.cmd_byte = st_r.cmd;
  assign link.cmd_we   = st_r.we;
  assign rdata_o       = st_r.rdata;
endmodule
`default_nettype wire

// [rtl/aux_cmd_dev.sv]
// device end: decodes auxiliary command bytes into latches and actions
// Notes on behaviour
// - cs in bit 0, code in bits 7..3
// - clear/set commands follow the cs bit
// - action commands act once per write
// - reset clears latches, sets software reset
// - trigger/local pulse when written 0 unset
// - trigger pulse five clocks or held high
// - software reset forces functions idle except IFC, REN, trigger, holds
// - software reset holds status bits at 0
// - host configures under reset, then clears it
// - DAC release carries valid-secondary flag
// - RFD release ends data holdoffs
// - hold-all holds off every data byte
// - hold-end holds off on EOI byte
// - cancel byte waiting in data out
// - return to local unless lockout
// - EOI sent with next data byte
// - listen/talk only held until cleared
// - standby drives ATN false
// - synchronous take at byte end
// - asynchronous take asserts ATN at once
// - parallel poll while cs 1, controller active
// - interface clear drives IFC, controller active
`timescale 1ns/1ps
`default_nettype none
`include "aux_cmd_defs.svh"
module aux_cmd_dev
  import aux_cmd_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  aux_cmd_if.dev    link,
  input  wire logic data_byte_i,
  input  wire logic eoi_in_i,
  input  wire logic atn_in_i,
  input  wire logic byte_sent_i,
  input  wire logic byte_end_i,
  input  wire logic local_lockout_i,
  input  wire logic remote_req_i,
  input  wire logic status_event_i,
  output logic      swrst_o,
  output logic      group_execute_pin_o,
  output logic      rfd_holdoff_o,
  output logic      dac_release_o,
  output logic      dac_valid_o,
  output logic      nba_cancel_o,
  output logic      eoi_out_o,
  output logic      atn_out_o,
  output logic      ifc_out_o,
  output logic      ren_out_o,
  output logic      listen_o,
  output logic      talk_o,
  output logic      ctrl_active_o,
  output logic      par_poll_o,
  output logic      remote_o,
  output logic      rlc_status_o
);
  import aux_cmd_pkg::*;
  typedef struct packed {
    logic swrst, hold_all, hold_end, trig, to_local, listen, talk;
    logic par_poll, ifc, ren, ctrl, atn, sync_pend, eoi_pend, eoi;
    logic rfd_hold, remote, rlc, dac_rel, dac_val, nba;
  } st_t;
  st_t st_r;
  st_t st_nxt;
  logic      trig_start;
  logic      trig_busy;
  aux_code_t code;
  logic      cs;

  function automatic logic is_cmd(input aux_code_t c, input aux_code_t k);
    is_cmd = link.cmd_we && (c == k);
  endfunction

  assign code = link.cmd_byte[`AUX_CODE_MSB:`AUX_CODE_LSB];
  assign cs   = link.cmd_byte[`AUX_CS_BIT];

  aux_trig_pulse u_trig (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (trig_start),
    .busy_o  (trig_busy)
  );

  // --------------------------------------------------------------------------
  // decode and state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    trig_start = 1'b0;
    st_nxt.dac_rel = 1'b0;
    st_nxt.nba = 1'b0;
    if (is_cmd(code, `AUX_C_SWRST)) st_nxt.swrst = cs;
    if (is_cmd(code, `AUX_C_HOLD_ALL)) st_nxt.hold_all = cs;
    if (is_cmd(code, `AUX_C_HOLD_END)) st_nxt.hold_end = cs;
    if (is_cmd(code, `AUX_C_DAC_REL)) begin
      st_nxt.dac_rel = 1'b1;
      st_nxt.dac_val = cs;
    end
    if (is_cmd(code, `AUX_C_NBA_FALSE)) st_nxt.nba = 1'b1;
    if (is_cmd(code, `AUX_C_TRIGGER)) begin
      // a pulse starts only from a cleared latch; clearing a held line just drops it
      if (!cs && !st_r.trig) trig_start = 1'b1;
      st_nxt.trig = cs;
    end
    // data holdoffs; a byte taken in the release cycle holds off again, so none slips past
    if (is_cmd(code, `AUX_C_RFD_REL)) st_nxt.rfd_hold = 1'b0;
    if (data_byte_i && !atn_in_i && (st_r.hold_all || (st_r.hold_end && eoi_in_i))) begin
      st_nxt.rfd_hold = 1'b1;
    end
    // remote/local; a change seen with the status clear still wins, so none is missed
    if (status_event_i) st_nxt.rlc = 1'b0;
    if (remote_req_i && !st_r.to_local && !st_r.remote) begin
      st_nxt.remote = 1'b1;
      st_nxt.rlc = 1'b1;
    end
    if (is_cmd(code, `AUX_C_TO_LOCAL)) begin
      st_nxt.to_local = cs;
      if (!local_lockout_i && st_r.remote && (cs || !st_r.to_local)) begin
        st_nxt.remote = 1'b0;
        st_nxt.rlc = 1'b1;
      end
    end
    // talker/listener only
    if (is_cmd(code, `AUX_C_LISTEN_ONLY)) st_nxt.listen = cs;
    if (is_cmd(code, `AUX_C_TALK_ONLY)) st_nxt.talk = cs;
    // end-or-identify on next byte, then drop by itself
    if (st_r.eoi && byte_sent_i) st_nxt.eoi = 1'b0;
    if (st_r.eoi_pend && !st_r.eoi) begin
      st_nxt.eoi = 1'b1;
      st_nxt.eoi_pend = 1'b0;
    end
    if (is_cmd(code, `AUX_C_FORCE_EOI)) st_nxt.eoi_pend = 1'b1;
    // controller
    if (is_cmd(code, `AUX_C_IFC)) begin
      st_nxt.ifc = cs;
      if (cs) begin
        st_nxt.ctrl = 1'b1;
        st_nxt.atn = 1'b1;
      end
    end
    if (is_cmd(code, `AUX_C_STANDBY) && st_r.ctrl) st_nxt.atn = 1'b0;
    if (is_cmd(code, `AUX_C_TAKE_ASYNC) && st_r.ctrl) begin
      st_nxt.atn = 1'b1;
      st_nxt.sync_pend = 1'b0;
    end
    if (is_cmd(code, `AUX_C_TAKE_SYNC) && st_r.ctrl) st_nxt.sync_pend = 1'b1;
    if (st_r.sync_pend && byte_end_i) begin
      st_nxt.atn = 1'b1;
      st_nxt.sync_pend = 1'b0;
    end
    if (is_cmd(code, `AUX_C_PAR_POLL)) st_nxt.par_poll = cs && st_r.ctrl;
    if (is_cmd(code, `AUX_C_REN)) st_nxt.ren = cs;
    // codes above the defined set match no branch and change nothing
    // applied last so it overrides any same-cycle change to the fields it forces idle
    if (st_r.swrst) begin
      st_nxt.listen = 1'b0;
      st_nxt.talk = 1'b0;
      st_nxt.ctrl = 1'b0;
      st_nxt.atn = 1'b0;
      st_nxt.sync_pend = 1'b0;
      st_nxt.par_poll = 1'b0;
      st_nxt.remote = 1'b0;
      st_nxt.rfd_hold = 1'b0;
      st_nxt.eoi = 1'b0;
      st_nxt.eoi_pend = 1'b0;
      st_nxt.rlc = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  // software reset comes up set so the host can configure before joining the bus
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.swrst <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign swrst_o             = st_r.swrst;
  assign group_execute_pin_o = st_r.trig || trig_busy;
  assign rfd_holdoff_o       = st_r.rfd_hold;
  assign dac_release_o       = st_r.dac_rel;
  assign dac_valid_o         = st_r.dac_val;
  assign nba_cancel_o        = st_r.nba;
  assign eoi_out_o           = st_r.eoi;
  assign atn_out_o           = st_r.atn;
  assign ifc_out_o           = st_r.ifc;
  assign ren_out_o           = st_r.ren;
  assign listen_o            = st_r.listen;
  assign talk_o              = st_r.talk;
  assign ctrl_active_o       = st_r.ctrl;
  assign par_poll_o          = st_r.par_poll;
  assign remote_o            = st_r.remote;
  assign rlc_status_o        = st_r.rlc;
endmodule
`default_nettype wire

// [tb/aux_cmd_checker.sv]
// concurrent checks on the command link and the decoder outputs
`timescale 1ns/1ps
`default_nettype none
module aux_cmd_checker (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_we,
  input wire logic       swrst_o,
  input wire logic       group_execute_pin_o,
  input wire logic       dac_release_o,
  input wire logic       dac_valid_o,
  input wire logic       atn_out_o,
  input wire logic       ifc_out_o,
  input wire logic       ren_out_o,
  input wire logic       listen_o,
  input wire logic       talk_o,
  input wire logic       ctrl_active_o,
  input wire logic       rfd_holdoff_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire [4:0] c = cmd_byte[7:3];
  // command checks other than the software reset and undefined-code ones skip commands taken while software reset holds the device
  wire       go = cmd_we && !swrst_o;
  rst_state_a: assert property (disable iff (1'b0) !rst_n_i |=> swrst_o && !ren_out_o)
    else $error("reset state wrong");
  swrst_follow_a: assert property (cmd_we && c == 5'h00 |=> swrst_o == $past(cmd_byte[0]))
    else $error("software reset latch wrong");
  swrst_idle_a: assert property (swrst_o [*2] |-> !(listen_o || talk_o || ctrl_active_o))
    else $error("functions active under software reset");
  trig_pulse_a: assert property (go && c == 5'h06 && !cmd_byte[0] && !group_execute_pin_o
    |=> group_execute_pin_o [*5] ##1 !group_execute_pin_o) else $error("trigger pulse wrong");
  dac_pulse_a: assert property (go && c == 5'h01 |=> dac_release_o ##1 !dac_release_o)
    else $error("release pulse wrong");
  ren_follow_a: assert property (go && c == 5'h10 |=> ren_out_o == $past(cmd_byte[0]))
    else $error("remote enable wrong");
  dac_valid_a: assert property (go && c == 5'h01 |=> dac_valid_o == $past(cmd_byte[0]))
    else $error("release valid flag wrong");
  swrst_hold_a: assert property (swrst_o [*2] |-> !rfd_holdoff_o && !atn_out_o)
    else $error("holdoff or attention under software reset");
  sic_ctrl_a: assert property (go && c == 5'h0F && cmd_byte[0] |=> ifc_out_o && ctrl_active_o)
    else $error("interface clear wrong");
  tca_atn_a: assert property (go && c == 5'h0C && ctrl_active_o |=> atn_out_o)
    else $error("async take failed");
  gts_atn_a: assert property (go && c == 5'h0B && ctrl_active_o |=> !atn_out_o)
    else $error("standby failed");
  undef_keep_a: assert property (cmd_we && c > 5'h10
    |=> $stable({ren_out_o, ifc_out_o, listen_o, talk_o, atn_out_o, swrst_o}))
    else $error("undefined code changed state");
  cover property (go && c == 5'h06 && !cmd_byte[0]);
  cover property (go && c == 5'h0F && cmd_byte[0]);
  cover property (cmd_we && c > 5'h10);
endmodule
`default_nettype wire

// [tb/test_gpib_auxiliary_command_decoder.sv]
// bench joining the host end and the device end over the command link
`timescale 1ns/1ps
`default_nettype none
module test_gpib_auxiliary_command_decoder;
  // ----------------------------------------
  // stimulus, ends and checker
  // ----------------------------------------
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [4:0] pz = 5'h00;
  logic       eoi_i = 1'b0;
  logic       llo_i = 1'b0;
  logic       atn_i = 1'b0;
  logic [7:0] rdata_o;
  logic       swr, trg, rfd, dac, dav, nba, eoi, atn, ifc, ren, lsn, tlk, ctl, ppl, rem, rlc;
  int         n_errors = 0;
  int         n_tests = 0;
  always #20 clk_i = ~clk_i;
  aux_cmd_if aux_cmd_if_inst ();
  aux_cmd_host aux_cmd_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(aux_cmd_if_inst.host));
  aux_cmd_dev aux_cmd_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(aux_cmd_if_inst.dev),
    .data_byte_i(pz[0]), .eoi_in_i(eoi_i), .atn_in_i(atn_i), .byte_sent_i(pz[1]),
    .byte_end_i(pz[2]), .local_lockout_i(llo_i), .remote_req_i(pz[3]), .status_event_i(pz[4]),
    .swrst_o(swr), .group_execute_pin_o(trg), .rfd_holdoff_o(rfd), .dac_release_o(dac),
    .dac_valid_o(dav), .nba_cancel_o(nba), .eoi_out_o(eoi), .atn_out_o(atn), .ifc_out_o(ifc),
    .ren_out_o(ren), .listen_o(lsn), .talk_o(tlk), .ctrl_active_o(ctl), .par_poll_o(ppl),
    .remote_o(rem), .rlc_status_o(rlc));
  aux_cmd_checker aux_cmd_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cmd_byte(aux_cmd_if_inst.cmd_byte), .cmd_we(aux_cmd_if_inst.cmd_we), .swrst_o(swr),
    .group_execute_pin_o(trg), .dac_release_o(dac), .dac_valid_o(dav), .atn_out_o(atn),
    .ifc_out_o(ifc), .ren_out_o(ren), .listen_o(lsn), .talk_o(tlk), .ctrl_active_o(ctl),
    .rfd_holdoff_o(rfd));
  // ----------------------------------------
  // tasks and sequence
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ends one cycle after the host latched the byte, just after the device updated, so outputs are settled
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic cmd(input logic [4:0] c, input logic cs);
    wr(2'h0, {c, 2'b00, cs});
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  task automatic pls(input int i, input logic e = 1'b0);
    @(posedge clk_i);
    pz[i] <= 1'b1;
    eoi_i <= e;
    @(posedge clk_i);
    pz[i] <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic t_boot();
    cmd(5'h09, 1'b1);
    chk(lsn, 1'b0);
    cmd(5'h00, 1'b0);
    chk(swr, 1'b0);
    cmd(5'h09, 1'b1);
    chk(lsn, 1'b1);
    cmd(5'h09, 1'b0);
    chk(lsn, 1'b0);
    cmd(5'h0A, 1'b1);
    chk(tlk, 1'b1);
    cmd(5'h0A, 1'b0);
    chk(tlk, 1'b0);
  endtask
  task automatic t_trig();
    int n;
    cmd(5'h06, 1'b0);
    n = 0;
    while (trg === 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
      #1;
    end
    chk(n == 5, 1'b1);
    cmd(5'h06, 1'b1);
    repeat (10) @(posedge clk_i);
    #1;
    chk(trg, 1'b1);
    cmd(5'h06, 1'b0);
    chk(trg, 1'b0);
  endtask
  task automatic t_ctrl();
    cmd(5'h0F, 1'b1);
    chk({ifc, ctl}, 2'b11);
    rd(2'h1, 8'h02);
    repeat (2500) @(posedge clk_i);
    rd(2'h1, 8'h03);
    rd(2'h3, 8'h00);
    cmd(5'h0F, 1'b0);
    chk(ifc, 1'b0);
    cmd(5'h0B, 1'b0);
    chk(atn, 1'b0);
    cmd(5'h0D, 1'b0);
    chk(atn, 1'b0);
    pls(2);
    chk(atn, 1'b1);
    cmd(5'h0B, 1'b0);
    cmd(5'h0C, 1'b0);
    chk(atn, 1'b1);
    cmd(5'h0E, 1'b1);
    chk(ppl, 1'b1);
    cmd(5'h0E, 1'b0);
    chk(ppl, 1'b0);
  endtask
  task automatic t_hold();
    cmd(5'h03, 1'b1);
    pls(0);
    chk(rfd, 1'b1);
    cmd(5'h02, 1'b0);
    chk(rfd, 1'b0);
    cmd(5'h03, 1'b0);
    cmd(5'h04, 1'b1);
    pls(0, 1'b0);
    chk(rfd, 1'b0);
    @(posedge clk_i);
    atn_i <= 1'b1;
    pls(0, 1'b1);
    chk(rfd, 1'b0);
    @(posedge clk_i);
    atn_i <= 1'b0;
    pls(0, 1'b1);
    chk(rfd, 1'b1);
    cmd(5'h02, 1'b0);
    chk(rfd, 1'b0);
    cmd(5'h04, 1'b0);
  endtask
  task automatic t_misc();
    cmd(5'h01, 1'b1);
    chk({dac, dav}, 2'b11);
    cmd(5'h01, 1'b0);
    chk({dac, dav}, 2'b10);
    cmd(5'h05, 1'b0);
    chk(nba, 1'b1);
    cmd(5'h08, 1'b0);
    @(posedge clk_i);
    #1;
    chk(eoi, 1'b1);
    pls(1);
    chk(eoi, 1'b0);
  endtask
  task automatic t_local();
    pls(3);
    cmd(5'h07, 1'b0);
    chk({rem, rlc}, 2'b01);
    pls(4);
    pls(3);
    chk({rem, rlc}, 2'b11);
    cmd(5'h07, 1'b1);
    pls(3);
    chk(rem, 1'b0);
    cmd(5'h07, 1'b0);
    pls(3);
    chk(rem, 1'b1);
    @(posedge clk_i);
    llo_i <= 1'b1;
    cmd(5'h07, 1'b0);
    chk(rem, 1'b1);
    llo_i <= 1'b0;
  endtask
  task automatic t_undef();
    cmd(5'h10, 1'b1);
    chk(ren, 1'b1);
    for (int c = 17; c < 32; c++) cmd(5'(c), 1'b1);
    chk({ren, swr, ifc}, 3'b100);
    wr(2'h3, 8'h80);
    chk(ren, 1'b1);
    cmd(5'h10, 1'b0);
    chk(ren, 1'b0);
    cmd(5'h00, 1'b1);
    // the idle forcing lands one cycle after the latch sets
    @(posedge clk_i);
    #1;
    chk({swr, ctl, atn}, 3'b100);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    #1;
    chk({swr, ren, trg}, 3'b100);
    rst_n_i <= 1'b1;
    t_boot();
    t_trig();
    t_ctrl();
    t_hold();
    t_misc();
    t_local();
    t_undef();
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    close_out();
  end
endmodule
`default_nettype wire
